/* addonly_eprom_memory_functions_test.sv */
`timescale 1ns/1ns

module addonly_eprom_memory_functions_test import eprom_mem_pkg::*; ;
    logic ref_clk, rst_b, bus_reset_pulse, rom_done, wr_bit_strobe;
    logic wr_bit_value, rd_slot_strobe, prog_volt_det, rd_bit;
    logic rd_bit_valid, seq_active, prog_refused, prog_done;
    logic [3:0] page_locked_map;
    logic [7:0] mem [128];
    logic [7:0] st [8];
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    slot_master_model mdl (.ref_clk(ref_clk),
        .bus_reset_pulse(bus_reset_pulse), .rom_done(rom_done),
        .wr_bit_strobe(wr_bit_strobe), .wr_bit_value(wr_bit_value),
        .rd_slot_strobe(rd_slot_strobe), .prog_volt_det(prog_volt_det),
        .rd_bit(rd_bit), .rd_bit_valid(rd_bit_valid),
        .prog_done(prog_done));
    eprom_mem_functions DUT (.ref_clk(ref_clk), .rst_b(rst_b),
        .bus_reset_pulse(bus_reset_pulse), .rom_done(rom_done),
        .wr_bit_strobe(wr_bit_strobe), .wr_bit_value(wr_bit_value),
        .rd_slot_strobe(rd_slot_strobe), .prog_volt_det(prog_volt_det),
        .rd_bit(rd_bit), .rd_bit_valid(rd_bit_valid),
        .seq_active(seq_active), .prog_refused(prog_refused),
        .prog_done(prog_done), .page_locked_map(page_locked_map));

    // CRC step over a byte, LSB first, with literal reflected polynomial.
    function automatic logic [7:0] crc8(input logic [7:0] c,
            input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
        end
        return c;
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Reads a field to its end, then its CRC and the idle ones.
    task automatic read_field(input logic [7:0] cmd, input logic [7:0] a);
        logic [7:0] hi, got, c, last, v;
        hi = 8'($urandom);
        last = (cmd == CMD_READ_DATA) ? 8'h7F : 8'h07;
        mdl.pulse(1'b1);
        mdl.send_byte(cmd);
        mdl.send_byte(a);
        mdl.send_byte(hi);
        mdl.get_byte(got);
        check(got, crc8(crc8(crc8(8'h00, cmd), a), hi));
        c = 8'h00;
        for (int i = a; i <= last; i++) begin
            v = (cmd == CMD_READ_DATA) ? mem[i] : st[i];
            mdl.get_byte(got);
            check(got, v);
            c = crc8(c, v);
        end
        mdl.get_byte(got);
        check(got, c);
        mdl.get_byte(got);
        check(got, 8'hFF);
        mdl.pulse(1'b0);
    endtask

    // Programs n bytes; a protected data page must keep its contents.
    task automatic write_field(input logic [7:0] cmd, input logic [7:0] a,
            input logic [7:0] d0, input int n);
        logic [7:0] d, got, c, v;
        logic done, lock;
        c = crc8(crc8(crc8(8'h00, cmd), a), 8'h00);
        mdl.pulse(1'b1);
        mdl.send_byte(cmd);
        mdl.send_byte(a);
        mdl.send_byte(8'h00);
        for (int k = 0; k < n; k++) begin
            d = (k == 0) ? d0 : 8'($urandom);
            if (k > 0) c = a;
            mdl.send_byte(d);
            mdl.get_byte(got);
            check(got, crc8(c, d));
            lock = (cmd == CMD_WRITE_DATA) && !st[0][a[6:5]];
            mdl.prog(done);
            if (cmd == CMD_WRITE_DATA) begin
                v = lock ? mem[a] : (mem[a] & d);
                mem[a] = v;
            end else begin
                v = st[a] & d;
                st[a] = v;
            end
            check({7'h00, prog_refused}, {7'h00, lock});
            mdl.get_byte(got);
            check(got, v);
            a++;
        end
        mdl.pulse(1'b0);
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Cycle ceiling well above the longest run; a hang is a mismatch.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            stop_test();
        end
    end

    // Main sequence; the blank image is mirrored first.
    initial begin
        logic [7:0] got, a;
        logic [1:0] p;
        rst_b = 1'b0;
        for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
        for (int i = 0; i < 8; i++) st[i] = (i == 7) ? 8'h00 : 8'hFF;
        void'($urandom(32'hAC66D16C));
        repeat (8) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        mdl.send_byte(CMD_READ_DATA);
        check({7'h00, seq_active}, 8'h00);
        mdl.pulse(1'b0);
        read_field(CMD_READ_DATA, 8'($urandom_range(127)));
        read_field(CMD_READ_DATA, 8'h7F);
        a = 8'h20 + 8'($urandom_range(30));
        write_field(CMD_WRITE_DATA, a, 8'($urandom), 2);
        write_field(CMD_WRITE_DATA, a, 8'($urandom), 1);
        p = 2'($urandom);
        write_field(CMD_WRITE_STATUS, 8'h01 + 8'(p), 8'hFD, 1);
        write_field(CMD_WRITE_STATUS, 8'h00, ~(8'h01 << p), 1);
        check({4'h0, page_locked_map}, {4'h0, ~st[0][3:0]});
        write_field(CMD_WRITE_DATA, {1'b0, p, 5'($urandom)}, 8'h00, 1);
        read_field(CMD_READ_DATA, 8'h00);
        read_field(CMD_READ_STATUS, 8'($urandom_range(7)));
        // Reset pulse in mid-read leaves the sequencer idle.
        mdl.pulse(1'b1);
        mdl.send_byte(CMD_READ_DATA);
        mdl.send_byte(8'h00);
        mdl.send_byte(8'h00);
        repeat (3) mdl.get_byte(got);
        mdl.pulse(1'b0);
        check({7'h00, seq_active}, 8'h00);
        // An unknown command only answers ones.
        mdl.pulse(1'b1);
        mdl.send_byte(8'h3C);
        mdl.get_byte(got);
        check(got, 8'hFF);
        mdl.pulse(1'b0);
        read_field(CMD_READ_STATUS, 8'h07);
        stop_test();
    end
endmodule

/* crc8_unit.sv */
`timescale 1ns/1ns

module crc8_unit import eprom_mem_pkg::*; (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Control.
    input wire logic crc_clear,
    input wire logic crc_load,
    input wire logic [7:0] crc_load_val,
    input wire logic crc_shift,
    input wire logic crc_bit,
    // Result.
    output logic [7:0] crc_val
);

    logic [7:0] crc_reg;
    logic [7:0] crc_next;
    logic fb;

    // Clear beats load, load beats shift; bits enter least significant first.
    always_comb begin
        fb = crc_reg[0] ^ crc_bit;
        crc_next = crc_reg;
        if (crc_clear) begin
            crc_next = CRC_INIT;
        end else if (crc_load) begin
            crc_next = crc_load_val;
        end else if (crc_shift) begin
            crc_next = (crc_reg >> 1) ^ (fb ? CRC_POLY_REFL : 8'h00);
        end
    end

    // Accumulator register.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_reg <= CRC_INIT;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign crc_val = crc_reg;

endmodule

/* eprom_mem_functions.sv */
`timescale 1ns/1ns


module eprom_mem_functions import eprom_mem_pkg::*; (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Events from the bus slot layer, same clock.
    input wire logic bus_reset_pulse,
    input wire logic rom_done,
    input wire logic wr_bit_strobe,
    input wire logic wr_bit_value,
    input wire logic rd_slot_strobe,
    // Programming voltage detector, asynchronous.
    input wire logic prog_volt_det,
    // Answer to the slot layer.
    output logic rd_bit,
    output logic rd_bit_valid,
    // Status.
    output logic seq_active,
    output logic prog_refused,
    output logic prog_done,
    output logic [3:0] page_locked_map
);

    // Command decoding shared by several decisions.
    function automatic logic cmd_known(input logic [7:0] c);
        cmd_known = (c == CMD_READ_DATA) || (c == CMD_READ_STATUS) ||
                    (c == CMD_WRITE_DATA) || (c == CMD_WRITE_STATUS);
    endfunction

    function automatic logic cmd_is_status(input logic [7:0] c);
        cmd_is_status = (c == CMD_READ_STATUS) || (c == CMD_WRITE_STATUS);
    endfunction

    function automatic logic cmd_is_write(input logic [7:0] c);
        cmd_is_write = (c == CMD_WRITE_DATA) || (c == CMD_WRITE_STATUS);
    endfunction

    mem_state_t state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [7:0] scratch_reg, scratch_next;
    logic [DATA_PTR_W-1:0] ptr_reg, ptr_next;
    logic armed_reg, armed_next;
    logic rd_bit_reg, rd_bit_next;
    logic rd_valid_reg, rd_valid_next;
    logic refused_reg, refused_next;
    logic done_reg, done_next;
    logic active_reg, active_next;
    logic [3:0] locked_reg, locked_next;
    logic prog_meta_reg, prog_sync_reg, prog_last_reg;

    logic [7:0] data_mem [DATA_BYTES];
    logic [7:0] stat_mem [STATUS_BYTES];

    logic crc_clear, crc_load, crc_shift, crc_bit;
    logic [7:0] crc_load_val, crc_val;
    logic [7:0] byte_in, cur_byte;
    logic [DATA_PTR_W-1:0] ptr_inc;
    logic is_status, is_write, page_locked, last_ptr, prog_edge;
    logic prog_en, prog_data_en, prog_stat_en;

    // Header, data-in and read stream bytes pass through one generator; verify bytes do not.
    crc8_unit u_crc (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .crc_clear(crc_clear),
        .crc_load(crc_load),
        .crc_load_val(crc_load_val),
        .crc_shift(crc_shift),
        .crc_bit(crc_bit),
        .crc_val(crc_val)
    );

    // The detector is an analog level, so it is synchronised before use.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prog_meta_reg <= 1'b0;
            prog_sync_reg <= 1'b0;
            prog_last_reg <= 1'b0;
        end else begin
            prog_meta_reg <= prog_volt_det;
            prog_sync_reg <= prog_meta_reg;
            prog_last_reg <= prog_sync_reg;
        end
    end

    assign prog_edge = prog_sync_reg & ~prog_last_reg;

    // Decode of the current field, byte and page protection.
    always_comb begin
        is_status = cmd_is_status(cmd_reg);
        is_write = cmd_is_write(cmd_reg);
        byte_in = {wr_bit_value, shift_reg[7:1]};
        ptr_inc = ptr_reg + 1'b1;
        if (is_status) begin
            cur_byte = stat_mem[ptr_reg[STAT_PTR_W-1:0]];
            last_ptr = (ptr_reg[STAT_PTR_W-1:0] == STAT_LAST);
        end else begin
            cur_byte = data_mem[ptr_reg];
            last_ptr = (ptr_reg == DATA_LAST);
        end
        // A programmed, hence zero, protect bit locks its page.
        page_locked = ~stat_mem[WP_BYTE_IDX][ptr_reg[DATA_PTR_W-1:PAGE_LSB]];
    end

    // Programming enables; a locked data page keeps its contents and the refusal shows on prog_refused.
    always_comb begin
        prog_data_en = prog_en & ~is_status & ~page_locked;
        prog_stat_en = prog_en & is_status;
    end

    // Sequencer: next state and datapath values.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        cmd_next = cmd_reg;
        scratch_next = scratch_reg;
        ptr_next = ptr_reg;
        rd_bit_next = rd_bit_reg;
        rd_valid_next = 1'b0;
        refused_next = refused_reg;
        done_next = 1'b0;
        crc_clear = 1'b0;
        crc_load = 1'b0;
        crc_load_val = BYTE_W'(ptr_inc);
        crc_shift = 1'b0;
        crc_bit = wr_bit_value;
        prog_en = 1'b0;

        // Arming from the ROM layer wins over a reset in the same cycle.
        armed_next = armed_reg;
        if (bus_reset_pulse) begin
            armed_next = 1'b0;
        end
        if (rom_done) begin
            armed_next = 1'b1;
        end

        // Every read slot gets an answer; released line reads as one.
        if (rd_slot_strobe) begin
            rd_valid_next = 1'b1;
            rd_bit_next = 1'b1;
        end

        if (bus_reset_pulse) begin
            // Any sequence is dropped here, with no trailing CRC.
            state_next = ST_IDLE;
            cnt_next = BIT_FIRST;
            crc_clear = 1'b1;
            refused_next = 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (armed_reg) begin
                        state_next = ST_CMD;
                        cnt_next = BIT_FIRST;
                        crc_clear = 1'b1;
                    end
                end
                ST_CMD, ST_ADDR_LO, ST_ADDR_HI, ST_DATA_IN: begin
                    if (wr_bit_strobe) begin
                        shift_next = byte_in;
                        crc_shift = 1'b1;
                        cnt_next = cnt_reg + 1'b1;
                        if (cnt_reg == BIT_LAST) begin
                            case (state_reg)
                                ST_CMD: begin
                                    cmd_next = byte_in;
                                    if (cmd_known(byte_in)) begin
                                        state_next = ST_ADDR_LO;
                                    end else begin
                                        state_next = ST_DEAD;
                                    end
                                end
                                ST_ADDR_LO: begin
                                    ptr_next = byte_in[DATA_PTR_W-1:0];
                                    state_next = ST_ADDR_HI;
                                end
                                ST_ADDR_HI: begin
                                    // High byte only enters the CRC; a stray
                                    // address shows up as a CRC mismatch.
                                    if (is_status) begin
                                        ptr_next = ptr_reg & STAT_PTR_MASK;
                                    end
                                    if (is_write) begin
                                        state_next = ST_DATA_IN;
                                    end else begin
                                        state_next = ST_HDR_CRC;
                                    end
                                end
                                ST_DATA_IN: begin
                                    scratch_next = byte_in;
                                    state_next = ST_HDR_CRC;
                                end
                                default: begin
                                    state_next = ST_IDLE;
                                end
                            endcase
                        end
                    end
                end
                ST_HDR_CRC, ST_TAIL_CRC: begin
                    // The accumulator stands still while it is sent.
                    if (rd_slot_strobe) begin
                        rd_bit_next = crc_val[cnt_reg];
                        cnt_next = cnt_reg + 1'b1;
                        if (cnt_reg == BIT_LAST) begin
                            if (state_reg == ST_TAIL_CRC) begin
                                state_next = ST_ONES;
                            end else if (is_write) begin
                                state_next = ST_PROG_WAIT;
                            end else begin
                                crc_clear = 1'b1;
                                state_next = ST_RD_STREAM;
                            end
                        end
                    end
                end
                ST_RD_STREAM: begin
                    if (rd_slot_strobe) begin
                        rd_bit_next = cur_byte[cnt_reg];
                        crc_bit = cur_byte[cnt_reg];
                        crc_shift = 1'b1;
                        cnt_next = cnt_reg + 1'b1;
                        if (cnt_reg == BIT_LAST) begin
                            if (last_ptr) begin
                                state_next = ST_TAIL_CRC;
                            end else begin
                                ptr_next = ptr_inc;
                            end
                        end
                    end
                end
                ST_PROG_WAIT: begin
                    if (prog_edge) begin
                        prog_en = 1'b1;
                        done_next = 1'b1;
                        if (!is_status && page_locked) begin
                            refused_next = 1'b1;
                        end
                        cnt_next = BIT_FIRST;
                        state_next = ST_VERIFY;
                    end
                end
                ST_VERIFY: begin
                    // Returns the stored byte, the AND of all accepted writes so far.
                    if (rd_slot_strobe) begin
                        rd_bit_next = cur_byte[cnt_reg];
                        cnt_next = cnt_reg + 1'b1;
                        if (cnt_reg == BIT_LAST) begin
                            if (last_ptr) begin
                                state_next = ST_ONES;
                            end else begin
                                ptr_next = ptr_inc;
                                crc_load = 1'b1;
                                state_next = ST_DATA_IN;
                            end
                        end
                    end
                end
                ST_ONES, ST_DEAD: begin
                    // Wait for a reset pulse.
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end

        active_next = (state_next != ST_IDLE) && (state_next != ST_DEAD);
        locked_next = ~stat_mem[WP_BYTE_IDX][PAGES-1:0];
    end

    // Sequencer registers.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cnt_reg <= BIT_FIRST;
            shift_reg <= ERASED_BYTE;
            cmd_reg <= ERASED_BYTE;
            scratch_reg <= ERASED_BYTE;
            ptr_reg <= '0;
            armed_reg <= 1'b0;
            rd_bit_reg <= 1'b1;
            rd_valid_reg <= 1'b0;
            refused_reg <= 1'b0;
            done_reg <= 1'b0;
            active_reg <= 1'b0;
            locked_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            cmd_reg <= cmd_next;
            scratch_reg <= scratch_next;
            ptr_reg <= ptr_next;
            armed_reg <= armed_next;
            rd_bit_reg <= rd_bit_next;
            rd_valid_reg <= rd_valid_next;
            refused_reg <= refused_next;
            done_reg <= done_next;
            active_reg <= active_next;
            locked_reg <= locked_next;
        end
    end

    // EPROM cells. Reset models a blank part; real cells would not reset.
    // Redirection bytes are stored like any other status byte.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DATA_BYTES; i++) begin
                data_mem[i] <= ERASED_BYTE;
            end
            for (int j = 0; j < STATUS_BYTES - 1; j++) begin
                stat_mem[j] <= ERASED_BYTE;
            end
            stat_mem[STATUS_BYTES-1] <= STATUS_LAST_VAL;
        end else begin
            if (prog_data_en) begin
                data_mem[ptr_reg] <= data_mem[ptr_reg] & scratch_reg;
            end
            if (prog_stat_en) begin
                stat_mem[ptr_reg[STAT_PTR_W-1:0]] <=
                    stat_mem[ptr_reg[STAT_PTR_W-1:0]] & scratch_reg;
            end
        end
    end

    assign rd_bit = rd_bit_reg;
    assign rd_bit_valid = rd_valid_reg;
    assign seq_active = active_reg;
    assign prog_refused = refused_reg;
    assign prog_done = done_reg;
    assign page_locked_map = locked_reg;

endmodule

/* eprom_mem_monitor.sv */
`timescale 1ns/1ns

module eprom_mem_monitor (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Slot layer events.
    input wire logic bus_reset_pulse,
    input wire logic rom_done,
    input wire logic wr_bit_strobe,
    input wire logic wr_bit_value,
    input wire logic rd_slot_strobe,
    input wire logic prog_volt_det,
    // Design answers.
    input wire logic rd_bit,
    input wire logic rd_bit_valid,
    input wire logic seq_active,
    input wire logic prog_refused,
    input wire logic prog_done,
    input wire logic [3:0] page_locked_map
);
    logic armed_reg;
    logic armed_next;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // Own copy of the arming flag; a set beats a clear in the same cycle.
    always_comb begin
        armed_next = armed_reg;
        if (bus_reset_pulse) armed_next = 1'b0;
        if (rom_done) armed_next = 1'b1;
    end

    // Register of the arming flag.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) armed_reg <= 1'b0;
        else armed_reg <= armed_next;
    end

    // Each read slot is answered exactly one cycle later.
    property p_rd_answer;
        rd_slot_strobe |=> rd_bit_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("slot unanswered");

    property p_rd_cause;
        rd_bit_valid |-> $past(rd_slot_strobe);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("stray answer");

    // The answered bit stands until the next slot.
    property p_rd_hold;
        !rd_bit_valid && !$past(bus_reset_pulse) |-> $stable(rd_bit);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("bit moved");

    property p_arm;
        $rose(seq_active) |-> armed_reg;
    endproperty
    a_arm: assert property (p_arm) else $error("active unarmed");

    property p_abort;
        bus_reset_pulse && !rom_done |-> ##[1:2] !seq_active;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort");

    property p_prog_cause;
        prog_done |-> $past(prog_volt_det, 2);
    endproperty
    a_prog_cause: assert property (p_prog_cause) else $error("no pulse");

    property p_refuse_cause;
        $rose(prog_refused) |-> $past(prog_volt_det, 2);
    endproperty
    a_refuse_cause: assert property (p_refuse_cause) else $error("refuse");

    property p_refuse_clear;
        bus_reset_pulse |=> !prog_refused;
    endproperty
    a_refuse_clear: assert property (p_refuse_clear) else $error("stuck");

    // A protect bit once set never comes back.
    property p_lock_keep;
        ($past(page_locked_map) & ~page_locked_map) == 4'h0;
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("unlocked");

    property p_lock_when;
        page_locked_map != $past(page_locked_map)
            |-> prog_done || $past(prog_done) || $past(prog_done, 2);
    endproperty
    a_lock_when: assert property (p_lock_when) else $error("lock");

    c_prog: cover property (prog_done);
    c_refuse: cover property ($rose(prog_refused));
    c_locked: cover property (page_locked_map != 4'h0);
endmodule

bind eprom_mem_functions eprom_mem_monitor mon (.ref_clk(ref_clk),
    .rst_b(rst_b), .bus_reset_pulse(bus_reset_pulse),
    .rom_done(rom_done), .wr_bit_strobe(wr_bit_strobe),
    .wr_bit_value(wr_bit_value), .rd_slot_strobe(rd_slot_strobe),
    .prog_volt_det(prog_volt_det), .rd_bit(rd_bit),
    .rd_bit_valid(rd_bit_valid), .seq_active(seq_active),
    .prog_refused(prog_refused), .prog_done(prog_done),
    .page_locked_map(page_locked_map));

/* eprom_mem_pkg.sv */
package eprom_mem_pkg;

    // Geometry of the data and status fields.
    localparam int BYTE_W = 8;
    localparam int DATA_BYTES = 128;
    localparam int PAGE_BYTES = 32;
    localparam int PAGES = 4;
    localparam int STATUS_BYTES = 8;
    localparam int DATA_PTR_W = 7;
    localparam int STAT_PTR_W = 3;
    localparam int PAGE_LSB = 5;

    // Last byte of each field and the mask applied to a status address.
    localparam logic [6:0] DATA_LAST = 7'h7F;
    localparam logic [2:0] STAT_LAST = 3'h7;
    localparam logic [6:0] STAT_PTR_MASK = 7'h07;

    // Status byte holding the page write-protect bits.
    localparam logic [2:0] WP_BYTE_IDX = 3'h0;

    // Command codes.
    localparam logic [7:0] CMD_READ_DATA = 8'hF0;
    localparam logic [7:0] CMD_READ_STATUS = 8'hAA;
    localparam logic [7:0] CMD_WRITE_DATA = 8'h0F;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h55;

    // Contents of unprogrammed cells and of the factory-written last byte.
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] STATUS_LAST_VAL = 8'h00;

    // CRC polynomial x^8 + x^5 + x^4 + 1 in bit-reversed form, and seed.
    localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // Bit positions of the last and the first bit of a byte.
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // Sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR_LO,
        ST_ADDR_HI,
        ST_DATA_IN,
        ST_HDR_CRC,
        ST_RD_STREAM,
        ST_TAIL_CRC,
        ST_PROG_WAIT,
        ST_VERIFY,
        ST_ONES,
        ST_DEAD
    } mem_state_t;

endpackage

/* slot_master_model.sv */
`timescale 1ns/1ns

module slot_master_model (
    // Clock.
    input wire logic ref_clk,
    // Requests to the device.
    output logic bus_reset_pulse,
    output logic rom_done,
    output logic wr_bit_strobe,
    output logic wr_bit_value,
    output logic rd_slot_strobe,
    output logic prog_volt_det,
    // Answers from the device.
    input wire logic rd_bit,
    input wire logic rd_bit_valid,
    input wire logic prog_done
);
    // All requests idle from time zero.
    initial begin
        bus_reset_pulse = 1'b0;
        rom_done = 1'b0;
        wr_bit_strobe = 1'b0;
        wr_bit_value = 1'b0;
        rd_slot_strobe = 1'b0;
        prog_volt_det = 1'b0;
    end

    // One ROM done or wire reset pulse; bits may follow two edges on.
    task automatic pulse(input logic rom);
        @(posedge ref_clk);
        #1;
        if (rom) rom_done = 1'b1;
        else bus_reset_pulse = 1'b1;
        @(posedge ref_clk);
        #1;
        rom_done = 1'b0;
        bus_reset_pulse = 1'b0;
        @(posedge ref_clk);
    endtask

    // A released data line shows the inverse, so a late sample is caught.
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            #1;
            wr_bit_strobe = 1'b1;
            wr_bit_value = b[i];
            @(posedge ref_clk);
            #1;
            wr_bit_strobe = 1'b0;
            wr_bit_value = ~b[i];
        end
    endtask

    // A slot without its valid pulse yields an unknown bit.
    task automatic get_byte(output logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            #1;
            rd_slot_strobe = 1'b1;
            @(posedge ref_clk);
            #1;
            rd_slot_strobe = 1'b0;
            b[i] = rd_bit_valid ? rd_bit : 1'bx;
        end
    endtask

    // Programming level held until the device takes it, bounded wait.
    task automatic prog(output logic done);
        @(posedge ref_clk);
        #1;
        prog_volt_det = 1'b1;
        done = 1'b0;
        for (int n = 0; n < 12 && !done; n++) begin
            @(posedge ref_clk);
            #1;
            done = prog_done;
        end
        prog_volt_det = 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule
